/* File: rtl/scmc_pkg.sv */
// package: constants and types of the system clock and power-mode controller
package scmc_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int FAST_2M_HZ = 2_000_000;
	localparam int FAST_4M_HZ = 4_000_000;
	localparam int FAST_8M_HZ = 8_000_000;
	localparam int SLOW_HZ = 32_000;
	localparam int HS_STABLE_NS = 16_000; // fast oscillator settling, least time
	localparam int LS_STABLE_NS = 100_000; // slow oscillator settling, least time
	localparam logic [7:0] FAST_DIV_2M = 8'(CLK_HZ / FAST_2M_HZ);
	localparam logic [7:0] FAST_DIV_4M = 8'(CLK_HZ / FAST_4M_HZ);
	localparam logic [7:0] FAST_DIV_8M = 8'(CLK_HZ / FAST_8M_HZ);
	localparam logic [11:0] SLOW_DIV = 12'(CLK_HZ / SLOW_HZ);
	localparam logic [11:0] HS_STABLE_CYC = 12'((HS_STABLE_NS * 40 + 999) / 1000);
	localparam logic [11:0] LS_STABLE_CYC = 12'((LS_STABLE_NS * 40 + 999) / 1000);

	// ----------------------------------------------------------------
	// register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SCC = 8'h00;
	localparam logic [7:0] ADDR_FOC = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
	localparam int SCC_SEL_LSB = 5;
	localparam int SCC_HK_BIT = 1;
	localparam int SCC_LK_BIT = 0;
	localparam int FOC_FREQ_LSB = 2;
	localparam int FOC_FLAG_BIT = 1;
	localparam int FOC_EN_BIT = 0;
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic [2:0] SEL_SUB = 3'h7;
	localparam logic [1:0] FREQ_RESET = 2'h0;
	localparam logic [1:0] FREQ_4M = 2'h1;
	localparam logic [1:0] FREQ_8M = 2'h2;
	localparam logic HS_EN_RESET = 1'b1;
	localparam int IRQ_W = 3;
	localparam int IRQ_HS_STABLE = 0;
	localparam int IRQ_SWITCHED = 1;
	localparam int IRQ_WOKE = 2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCMC_RUN = 2'b01,
		SCMC_HALT = 2'b10
	} scmc_mode_e;

	// one-cycle enables standing for each clock
	typedef struct packed {
		logic cpu;
		logic sys;
		logic fast;
		logic sub;
		logic slow;
	} scmc_clk_s;
endpackage

/* File: rtl/scmc_top.sv */
// system clock selection and power-mode control with APB registers
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - clk_sel picks fast divided 1..64 or subsidiary
// - subsidiary from slow RC, fast from fast RC
// - running fast mode keeps all clocks on
// - subsidiary mode: fast clock follows hs_osc_en
// - stop, no keeps: only slow RC runs
// - stop, slow keep: subsidiary on, fast off
// - stop, both keeps: only CPU stops
// - stop, fast keep: fast on, subsidiary off
// - slow RC clock never stops
// - switch to subsidiary waits slow RC stable
// - hs_freq_sel picks 2, 4, 8, 2 MHz
// - enable or retune clears then sets stable flag
// - new fast frequency applies once stable
// - hs_osc_en enables fast RC, resets to one
// - unimplemented register bits read zero
module scmc_top
	import scmc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu side
	input wire logic halt_req,
	input wire logic wake_req,
	output logic cpu_halted,
	// clock enables and interrupt
	output scmc_clk_s clk_en,
	output logic irq
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [2:0] clk_sel;
	logic hs_keep_halt;
	logic ls_keep_halt;
	logic [1:0] hs_freq_sel;
	logic hs_osc_en;
	logic hs_stable_flag;
	logic [1:0] active_freq;
	logic [2:0] sel_active;
	scmc_mode_e mode;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic [11:0] hs_cnt;
	logic [11:0] ls_cnt;
	logic slow_stable;
	logic [11:0] slow_cnt;
	logic [7:0] fast_cnt;
	logic [5:0] div_cnt;
	logic osc_on;
	logic osc_on_q;
	logic wr_acc;
	logic hs_restart;
	logic hs_set;
	logic slow_pulse;
	logic fast_pulse;
	logic fast_div_pulse;
	logic [7:0] fast_period;
	logic [5:0] div_mask;
	logic sel_to_sub;
	logic switch_ok;
	logic sys_on;
	logic sub_on;
	logic [IRQ_W-1:0] ev;
	logic [31:0] next_rdata;
	logic next_err;
	scmc_clk_s next_clk;

	// ----------------------------------------------------------------
	// apb slave: one wait-free access phase
	// ----------------------------------------------------------------
	assign wr_acc = psel & penable & pready & pwrite;

	// read mux, unimplemented bits tie to zero
	always_comb begin
		next_rdata = 32'h0;
		next_err = 1'b0;
		case (paddr)
			ADDR_SCC: next_rdata[7:0] = {clk_sel, 3'h0, hs_keep_halt, ls_keep_halt};
			ADDR_FOC: next_rdata[7:0] = {4'h0, hs_freq_sel, hs_stable_flag, hs_osc_en};
			ADDR_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
			ADDR_IRQ_CLR: next_rdata = 32'h0; // write-only
			ADDR_IRQ_EN: next_rdata[IRQ_W-1:0] = irq_en;
			default: next_err = 1'b1;
		endcase
	end

	// answer registered in setup so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0 : next_rdata;
			pslverr <= next_err;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// control registers; the stable flag has no write path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_sel <= SEL_RESET;
			hs_keep_halt <= 1'b0;
			ls_keep_halt <= 1'b0;
			hs_freq_sel <= FREQ_RESET;
			hs_osc_en <= HS_EN_RESET;
			irq_en <= '0;
		end else if (wr_acc) begin
			case (paddr)
				ADDR_SCC: begin
					clk_sel <= pwdata[SCC_SEL_LSB +: 3];
					hs_keep_halt <= pwdata[SCC_HK_BIT];
					ls_keep_halt <= pwdata[SCC_LK_BIT];
				end
				ADDR_FOC: begin
					hs_freq_sel <= pwdata[FOC_FREQ_LSB +: 2];
					hs_osc_en <= pwdata[FOC_EN_BIT];
				end
				ADDR_IRQ_EN: irq_en <= pwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// power mode: stop instruction in, wake source out
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= SCMC_RUN;
		end else begin
			case (mode)
				SCMC_RUN: if (halt_req) mode <= SCMC_HALT;
				SCMC_HALT: if (wake_req) mode <= SCMC_RUN;
				default: mode <= SCMC_RUN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// fast oscillator: power, settling, frequency
	// ----------------------------------------------------------------
	// in run the fast source is needed when selected, asked for or enabled;
	// a pending return from slow mode must restart it or the switch never ends
	always_comb begin
		if (mode == SCMC_HALT) begin
			osc_on = hs_keep_halt;
		end else begin
			osc_on = hs_osc_en | (sel_active != SEL_SUB) | (clk_sel != SEL_SUB);
		end
	end

	// enabling, retuning or restarting after a stop all resettle
	assign hs_restart = (wr_acc && paddr == ADDR_FOC &&
		((pwdata[FOC_EN_BIT] && !hs_osc_en) ||
		(pwdata[FOC_FREQ_LSB +: 2] != hs_freq_sel))) ||
		(osc_on && !osc_on_q);
	assign hs_set = osc_on && !hs_restart && !hs_stable_flag && hs_cnt == 12'h0;

	// settling counter; flag clears first, then sets when settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_on_q <= 1'b0;
			hs_cnt <= HS_STABLE_CYC;
			hs_stable_flag <= 1'b0;
			active_freq <= FREQ_RESET;
		end else begin
			osc_on_q <= osc_on;
			if (!osc_on || hs_restart) begin
				hs_cnt <= HS_STABLE_CYC;
				hs_stable_flag <= 1'b0;
			end else if (hs_cnt != 12'h0) begin
				hs_cnt <= hs_cnt - 12'h1;
			end else if (hs_set) begin
				hs_stable_flag <= 1'b1;
				active_freq <= hs_freq_sel;
			end
		end
	end

	// frequency code to cycles per fast tick; code 3 falls back to 2 MHz
	always_comb begin
		case (active_freq)
			FREQ_4M: fast_period = FAST_DIV_4M;
			FREQ_8M: fast_period = FAST_DIV_8M;
			default: fast_period = FAST_DIV_2M;
		endcase
	end

	// fast tick only from a running, settled oscillator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_cnt <= 8'h0;
		end else if (!osc_on || !hs_stable_flag || fast_cnt >= fast_period - 8'h1) begin
			fast_cnt <= 8'h0;
		end else begin
			fast_cnt <= fast_cnt + 8'h1;
		end
	end
	assign fast_pulse = osc_on && hs_stable_flag && fast_cnt == 8'h0;

	// prescaler for the divided fast clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 6'h0;
		end else if (fast_pulse) begin
			div_cnt <= div_cnt + 6'h1;
		end
	end
	assign div_mask = ~6'(6'h3F << sel_active);
	assign fast_div_pulse = fast_pulse && (div_cnt & div_mask) == 6'h0;

	// ----------------------------------------------------------------
	// slow oscillator: free running, never gated
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_cnt <= 12'h0;
			ls_cnt <= LS_STABLE_CYC;
			slow_stable <= 1'b0;
		end else begin
			slow_cnt <= (slow_cnt >= SLOW_DIV - 12'h1) ? 12'h0 : slow_cnt + 12'h1;
			if (ls_cnt != 12'h0) begin
				ls_cnt <= ls_cnt - 12'h1;
			end else begin
				slow_stable <= 1'b1;
			end
		end
	end
	assign slow_pulse = slow_cnt == 12'h0;

	// ----------------------------------------------------------------
	// system clock source switch
	// ----------------------------------------------------------------
	// switching between ticks means no tick is cut or doubled
	assign sel_to_sub = clk_sel == SEL_SUB;
	assign switch_ok = sel_active != clk_sel && !slow_pulse && !fast_pulse &&
		(sel_to_sub ? slow_stable : hs_stable_flag);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_active <= SEL_RESET;
		end else if (switch_ok) begin
			sel_active <= clk_sel;
		end
	end

	// ----------------------------------------------------------------
	// clock gating per mode
	// ----------------------------------------------------------------
	always_comb begin
		if (mode == SCMC_HALT) begin
			sub_on = ls_keep_halt;
			sys_on = (sel_active == SEL_SUB) ? ls_keep_halt : hs_keep_halt;
		end else begin
			sub_on = 1'b1;
			sys_on = 1'b1;
		end
		next_clk.slow = slow_pulse;
		next_clk.sub = slow_pulse & sub_on;
		next_clk.fast = fast_pulse;
		next_clk.sys = sys_on &
			((sel_active == SEL_SUB) ? slow_pulse : fast_div_pulse);
		next_clk.cpu = next_clk.sys & (mode == SCMC_RUN);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_en <= '0;
			cpu_halted <= 1'b0;
		end else begin
			clk_en <= next_clk;
			cpu_halted <= mode == SCMC_HALT;
		end
	end

	// ----------------------------------------------------------------
	// interrupts: sticky status, set beats clear
	// ----------------------------------------------------------------
	assign ev[IRQ_HS_STABLE] = hs_set;
	assign ev[IRQ_SWITCHED] = switch_ok;
	assign ev[IRQ_WOKE] = mode == SCMC_HALT && wake_req;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_acc && paddr == ADDR_IRQ_CLR) begin
				irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | ev;
			end else begin
				irq_stat <= irq_stat | ev;
			end
			irq <= |(irq_stat & irq_en);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_retune;
		wr_acc && paddr == ADDR_FOC && osc_on && hs_stable_flag &&
			pwdata[FOC_FREQ_LSB +: 2] != hs_freq_sel;
	endsequence
	property p_retune_clears;
		s_retune |=> !hs_stable_flag ##1 !hs_stable_flag;
	endproperty
	a_retune_clears: assert property (p_retune_clears)
		else $error("stable flag not cleared on retune");

	property p_freq_on_stable;
		$changed(active_freq) |-> $rose(hs_stable_flag);
	endproperty
	a_freq_on_stable: assert property (p_freq_on_stable)
		else $error("fast frequency changed before stable");

	property p_sub_needs_stable;
		$changed(sel_active) && sel_active == SEL_SUB |-> $past(slow_stable);
	endproperty
	a_sub_needs_stable: assert property (p_sub_needs_stable)
		else $error("switched to subsidiary before slow RC stable");

	property p_slow_free;
		slow_pulse |-> ##1 clk_en.slow ##1 !clk_en.slow;
	endproperty
	a_slow_free: assert property (p_slow_free)
		else $error("slow RC clock gated");

	property p_sleep;
		mode == SCMC_HALT && !hs_keep_halt && !ls_keep_halt |=>
			!clk_en.sys && !clk_en.fast && !clk_en.sub && !clk_en.cpu;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("clock running in sleep");

	property p_idle_slow;
		mode == SCMC_HALT && !hs_keep_halt && ls_keep_halt && slow_pulse |=>
			clk_en.sub && !clk_en.fast;
	endproperty
	a_idle_slow: assert property (p_idle_slow)
		else $error("slow idle gating wrong");

	property p_idle_fast;
		mode == SCMC_HALT && hs_keep_halt && !ls_keep_halt |=> !clk_en.sub;
	endproperty
	a_idle_fast: assert property (p_idle_fast)
		else $error("subsidiary running in fast idle");

	property p_idle_both;
		mode == SCMC_HALT && hs_keep_halt && ls_keep_halt && fast_div_pulse &&
			sel_active != SEL_SUB |=> clk_en.sys && clk_en.fast && !clk_en.cpu;
	endproperty
	a_idle_both: assert property (p_idle_both)
		else $error("clock stopped in full idle");

	property p_sub_sys;
		mode == SCMC_RUN && sel_active == SEL_SUB && slow_pulse |=> clk_en.sys && clk_en.cpu;
	endproperty
	a_sub_sys: assert property (p_sub_sys)
		else $error("subsidiary system clock missing");

	property p_read_zero;
		psel && !penable && !pwrite && paddr == ADDR_SCC |=> prdata[4:2] == 3'h0;
	endproperty
	a_read_zero: assert property (p_read_zero)
		else $error("unimplemented bits read nonzero");
endmodule

/* File: test/scmc_cpu_model.sv */
// cpu-side model: stop and wake pulses, clock-enable pulse counts
`timescale 1ns/10ps
module scmc_cpu_model
	import scmc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// controller side
	input wire scmc_clk_s clk_en,
	input wire logic cpu_halted,
	output logic halt_req,
	output logic wake_req
);
	int cnt[5];

	// quiet until asked
	initial begin
		halt_req = 1'b0;
		wake_req = 1'b0;
	end

	// one-cycle pulse; a stop is only issued while running, a wake only while halted
	task automatic pulse(input bit wake);
		@(posedge pclk);
		halt_req <= !wake && !cpu_halted;
		wake_req <= wake && cpu_halted;
		@(posedge pclk);
		halt_req <= 1'b0;
		wake_req <= 1'b0;
	endtask

	// counts each enable over a window; index 4 cpu down to 0 slow
	task automatic count(input int n);
		cnt = '{default: 0};
		repeat (n) begin
			@(posedge pclk);
			for (int i = 0; i < 5; i++) begin
				cnt[i] += int'(clk_en[i]);
			end
		end
	endtask
endmodule

/* File: test/test_system_clock_mode_control.sv */
// self-checking bench for the clock and power-mode controller
`timescale 1ns/10ps
module test_system_clock_mode_control
	import scmc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rq;
	logic pready, pslverr, cpu_halted, irq, halt_req, wake_req, re;
	scmc_clk_s clk_en;
	int bad_count = 0;
	int num_checks = 0;
	int sel;
	int per;
	int sp;

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	scmc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .halt_req(halt_req), .wake_req(wake_req),
		.cpu_halted(cpu_halted), .clk_en(clk_en), .irq(irq));

	scmc_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.cpu_halted(cpu_halted), .halt_req(halt_req), .wake_req(wake_req));

	// ----------------------------------------------------------------
	// expectations and checks
	// ----------------------------------------------------------------
	function automatic int fast_per(input int f);
		return (f == 1) ? int'(FAST_DIV_4M) : (f == 2) ? int'(FAST_DIV_8M) : int'(FAST_DIV_2M);
	endfunction

	function automatic int sys_per(input int s, input int fp);
		return (s == 7) ? int'(SLOW_DIV) : fp << s;
	endfunction

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t value %h want %h", $time, got, exp);
		end
	endtask

	// pulse counts may be off by one at the window edges
	task automatic cmp_cnt(input int got, input int exp);
		num_checks++;
		if (got > exp + 1 || got < exp - 1 || (exp == 0 && got != 0)) begin
			bad_count++;
			$display("MISMATCH t=%0t count %0d want %0d", $time, got, exp);
		end
	endtask

	// one apb transfer; holds everything until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp_val(rq, exp);
	endtask

	// poll the stable flag; a stuck flag is left to the watchdog
	task automatic wait_stable();
		do begin
			apb(1'b0, ADDR_FOC, 32'h0);
		end while (rq[FOC_FLAG_BIT] !== 1'b1);
	endtask

	task automatic chk(input int win, input int fp, input bit sub, input bit cpu);
		u_cpu.count(win);
		cmp_cnt(u_cpu.cnt[4], (cpu && sp > 0) ? win / sp : 0);
		cmp_cnt(u_cpu.cnt[3], sp > 0 ? win / sp : 0);
		cmp_cnt(u_cpu.cnt[2], fp > 0 ? win / fp : 0);
		cmp_cnt(u_cpu.cnt[1], sub ? win / int'(SLOW_DIV) : 0);
		cmp_cnt(u_cpu.cnt[0], win / int'(SLOW_DIV));
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// watchdog against a hung handshake; tests need about 80k cycles
	initial begin
		repeat (95000) @(posedge pclk);
		bad_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		print_verdict();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h7c76));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(ADDR_SCC, 32'h0);
		rd_chk(ADDR_FOC, 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		cmp_val(rq, 32'h0);
		cmp_val(32'(re), 32'h1);
		wait_stable();
		apb(1'b1, ADDR_FOC, 32'h1);
		rd_chk(ADDR_FOC, 32'h3);
		apb(1'b1, ADDR_SCC, 32'h1C | 32'($urandom_range(0, 3) << 8));
		rd_chk(ADDR_SCC, 32'h0);
		$display("test reset done");
		// interrupt enabled, raised and cleared
		apb(1'b1, ADDR_IRQ_EN, 32'h1);
		repeat (2) @(posedge pclk);
		cmp_val(32'(irq), 32'h1);
		apb(1'b1, ADDR_IRQ_CLR, 32'h1);
		repeat (2) @(posedge pclk);
		cmp_val(32'(irq), 32'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'h0);
		$display("test irq done");
		// every fast divide code
		per = fast_per(0);
		for (sel = 0; sel < 7; sel++) begin
			apb(1'b1, ADDR_SCC, 32'(sel << SCC_SEL_LSB));
			repeat (300) @(posedge pclk);
			sp = sys_per(sel, per);
			chk(2560, per, 1'b1, 1'b1);
		end
		$display("test divide done");
		// every frequency code, flag clears then sets
		apb(1'b1, ADDR_SCC, 32'h0);
		for (int k = 1; k < 5; k++) begin
			// last pass returns to code 00, the configured frequency
			apb(1'b1, ADDR_FOC, 32'(((k % 4) << FOC_FREQ_LSB) | 1));
			rd_chk(ADDR_FOC, 32'(((k % 4) << FOC_FREQ_LSB) | 1));
			wait_stable();
			per = fast_per(k % 4);
			sp = per;
			chk(2000, per, 1'b1, 1'b1);
		end
		$display("test frequency done");
		// slow mode with the fast oscillator on, then off
		apb(1'b1, ADDR_SCC, 32'hE0);
		repeat (300) @(posedge pclk);
		sp = sys_per(7, per);
		chk(3750, per, 1'b1, 1'b1);
		apb(1'b1, ADDR_FOC, 32'h0);
		rd_chk(ADDR_FOC, 32'h0);
		chk(3750, 0, 1'b1, 1'b1);
		// leaving slow mode must restart the stopped fast oscillator
		apb(1'b1, ADDR_SCC, 32'h0);
		wait_stable();
		apb(1'b1, ADDR_FOC, 32'h1);
		wait_stable();
		sp = per;
		chk(2000, per, 1'b1, 1'b1);
		$display("test slow done");
		// every keep combination, fast and subsidiary source
		for (int m = 0; m < 8; m++) begin
			sel = m[2] ? 7 : $urandom_range(0, 6);
			apb(1'b1, ADDR_SCC, 32'(sel << SCC_SEL_LSB) | 32'(m[1:0]));
			repeat (300) @(posedge pclk);
			u_cpu.pulse(1'b0);
			sp = ((sel == 7) ? m[0] : m[1]) ? sys_per(sel, per) : 0;
			// enables launched at the stop edge still carry run gating
			@(posedge pclk);
			chk(3750, m[1] ? per : 0, m[0], 1'b0);
			cmp_val(32'(cpu_halted), 32'h1);
			u_cpu.pulse(1'b1);
			// mode leaves halt at the wake edge, the flag one edge later
			repeat (2) @(posedge pclk);
			cmp_val(32'(cpu_halted), 32'h0);
			wait_stable();
		end
		cmp_val(32'(irq), 32'h0);
		apb(1'b1, ADDR_IRQ_EN, 32'h4);
		repeat (2) @(posedge pclk);
		cmp_val(32'(irq), 32'h1);
		apb(1'b1, ADDR_IRQ_CLR, 32'h4);
		repeat (2) @(posedge pclk);
		cmp_val(32'(irq), 32'h0);
		$display("test halt done");
		print_verdict();
	end
endmodule
